/* File: design/imra_pkg.sv */
// Package: register map, field layout and reset values of the management register block
package imra_pkg;

  // Register offsets on the management register port
  localparam logic [4:0] IMRA_OFF_DIAG_AUTORUN = 5'h09;
  localparam logic [4:0] IMRA_OFF_IND_CTRL     = 5'h0d;
  localparam logic [4:0] IMRA_OFF_IND_WINDOW   = 5'h0e;
  localparam logic [4:0] IMRA_OFF_INT_TEST     = 5'h11;

  // Reset values
  localparam logic [15:0] IMRA_RST_DIAG_AUTORUN = 16'h2000;
  localparam logic [15:0] IMRA_RST_IND_CTRL     = 16'h0000;
  localparam logic [15:0] IMRA_RST_INT_TEST     = 16'h010b;

  // Field positions
  localparam int IMRA_BIT_AUTORUN  = 8;
  localparam int IMRA_BIT_INT_POL  = 3;
  localparam int IMRA_BIT_INT_TEST = 2;

  // Device address values accepted by the window
  localparam logic [4:0] IMRA_DEVAD_VEND = 5'h1f;
  localparam logic [4:0] IMRA_DEVAD_PMA  = 5'h01;

  // Highest vendor extended register offset
  localparam logic [15:0] IMRA_VEND_MAX = 16'h04d1;

  typedef enum logic [1:0] {
    IMRA_CMD_ADDR   = 2'b00,
    IMRA_CMD_DATA   = 2'b01,
    IMRA_CMD_INC_RW = 2'b10,
    IMRA_CMD_INC_WR = 2'b11
  } imra_cmd_t;

  // Management register port request
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [4:0]  addr;
    logic [15:0] wdata;
  } imra_req_t;

  // Extended space access request
  typedef struct packed {
    logic        vend;
    logic        rd;
    logic        wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } imra_ext_t;

endpackage

/* File: design/imra_ptr.sv */
// Module: per-space address pointer with post-advance control
`timescale 1ns/10ps
module imra_ptr (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // Control
  input  wire logic        sel,
  input  wire logic        load,
  input  wire logic [15:0] load_val,
  input  wire logic        advance,
  // State
  output logic [15:0]      ptr
);
  import imra_pkg::*;

  logic [15:0] ptr_q;

  always_ff @(posedge clk) begin
    if (reset) begin
      ptr_q <= 16'h0000;
    end else if (sel && load) begin
      ptr_q <= load_val;
    end else if (sel && advance) begin
      ptr_q <= ptr_q + 16'h0001;
    end
  end

  assign ptr = ptr_q;

endmodule

/* File: design/imra_top.sv */
// Module: management registers with indirect extended window and interrupt test
//
// Overview of operation
// - Auto-run bit starts diagnostics on link loss
// - Command 00 address, 01 data, 10 advancing
// - Command 11 advances pointer on writes only
// - Device address field picks the target space
// - All-ones address routes to vendor space
// - Address 00001 routes to PMA/PMD space
// - Other device addresses are ignored entirely
// - Command 00 reaches address, else data
// - Polarity bit sets idle and active pin level
// - Test bit forces the interrupt output
// - Forced interrupt lasts while test bit set
`timescale 1ns/10ps
module imra_top (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // Management register port
  input  wire imra_pkg::imra_req_t reg_req,
  output logic [15:0]              reg_rdata,
  // Extended register spaces
  output imra_pkg::imra_ext_t      ext_req,
  input  wire logic [15:0]         vend_rdata,
  input  wire logic [15:0]         pma_rdata,
  // Link and diagnostics
  input  wire logic                link_up,
  output logic                     diag_start,
  // Interrupts
  input  wire logic                event_irq,
  output logic                     int_pin
);
  import imra_pkg::*;

  logic [15:0] autorun_q;
  logic [15:0] ctrl_q;
  logic [15:0] inttest_q;
  logic        link_q;
  logic        diag_start_q;
  logic        int_pin_q;
  logic [15:0] rdata_q;
  logic [15:0] vend_ptr;
  logic [15:0] pma_ptr;
  logic [15:0] cur_ptr;
  imra_cmd_t   cmd;
  logic [4:0]  devad;
  logic        dev_vend;
  logic        dev_pma;
  logic        dev_ok;
  logic        win_rd;
  logic        win_wr;
  logic        is_addr;
  logic        adv;
  logic        int_active;

  // Shared register decode
  function automatic logic hit(input imra_req_t r, input logic [4:0] off);
    return r.addr == off;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Window decode

  assign cmd      = imra_cmd_t'(ctrl_q[15:14]);
  assign devad    = ctrl_q[4:0];
  assign dev_vend = (devad == IMRA_DEVAD_VEND);
  assign dev_pma  = (devad == IMRA_DEVAD_PMA);
  assign dev_ok   = dev_vend || dev_pma;
  assign win_rd   = reg_req.rd && hit(reg_req, IMRA_OFF_IND_WINDOW);
  assign win_wr   = reg_req.wr && hit(reg_req, IMRA_OFF_IND_WINDOW);
  assign is_addr  = (cmd == IMRA_CMD_ADDR);
  assign cur_ptr  = dev_vend ? vend_ptr : pma_ptr;

  // Post-advance choice per command
  always_comb begin
    case (cmd)
      IMRA_CMD_ADDR:   adv = 1'b0;
      IMRA_CMD_DATA:   adv = 1'b0;
      IMRA_CMD_INC_RW: adv = win_rd || win_wr;
      IMRA_CMD_INC_WR: adv = win_wr;
      default:         adv = 1'b0;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-space pointers

  imra_ptr u_vend_ptr (
    .clk      (clk),
    .reset    (reset),
    .sel      (dev_vend),
    .load     (win_wr && is_addr),
    .load_val (reg_req.wdata),
    .advance  (adv && !is_addr),
    .ptr      (vend_ptr)
  );

  imra_ptr u_pma_ptr (
    .clk      (clk),
    .reset    (reset),
    .sel      (dev_pma),
    .load     (win_wr && is_addr),
    .load_val (reg_req.wdata),
    .advance  (adv && !is_addr),
    .ptr      (pma_ptr)
  );

  // Data access reaches the space only for a supported address
  always_comb begin
    ext_req.vend  = dev_vend;
    ext_req.rd    = win_rd && !is_addr && dev_ok;
    ext_req.wr    = win_wr && !is_addr && dev_ok;
    ext_req.addr  = cur_ptr;
    ext_req.wdata = reg_req.wdata;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Direct registers

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_q <= IMRA_RST_IND_CTRL;
    end else if (reg_req.wr && hit(reg_req, IMRA_OFF_IND_CTRL)) begin
      // Bits 13:5 read only zero
      ctrl_q <= {reg_req.wdata[15:14], 9'h000, reg_req.wdata[4:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      autorun_q <= IMRA_RST_DIAG_AUTORUN;
    end else if (reg_req.wr && hit(reg_req, IMRA_OFF_DIAG_AUTORUN)) begin
      autorun_q <= reg_req.wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      inttest_q <= IMRA_RST_INT_TEST;
    end else if (reg_req.wr && hit(reg_req, IMRA_OFF_INT_TEST)) begin
      inttest_q <= reg_req.wdata;
    end
  end

  // Read data registered one cycle after the read strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (reg_req.rd) begin
      case (reg_req.addr)
        IMRA_OFF_DIAG_AUTORUN: rdata_q <= autorun_q;
        IMRA_OFF_IND_CTRL:     rdata_q <= ctrl_q;
        IMRA_OFF_INT_TEST:     rdata_q <= inttest_q;
        IMRA_OFF_IND_WINDOW: begin
          if (!dev_ok) begin
            rdata_q <= 16'h0000;
          end else if (is_addr) begin
            rdata_q <= cur_ptr;
          end else begin
            rdata_q <= dev_vend ? vend_rdata : pma_rdata;
          end
        end
        default:               rdata_q <= 16'h0000;
      endcase
    end
  end

  assign reg_rdata = rdata_q;

  //////////////////////////////////////////////////////////////////////////////
  // Auto-run on link loss

  always_ff @(posedge clk) begin
    if (reset) begin
      link_q <= 1'b0;
    end else begin
      link_q <= link_up;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      diag_start_q <= 1'b0;
    end else begin
      diag_start_q <= link_q && !link_up && autorun_q[IMRA_BIT_AUTORUN];
    end
  end

  assign diag_start = diag_start_q;

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt pin

  // Test bit holds the pin active until software clears it
  assign int_active = event_irq || inttest_q[IMRA_BIT_INT_TEST];

  always_ff @(posedge clk) begin
    if (reset) begin
      int_pin_q <= 1'b1;
    end else begin
      int_pin_q <= int_active ^ inttest_q[IMRA_BIT_INT_POL];
    end
  end

  assign int_pin = int_pin_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks

  // Fall is judged on the pin itself, not on the internal delay flop
  chk_autorun_start: assert property (@(posedge clk) disable iff (reset)
    ($fell(link_up) && !$past(reset) && autorun_q[IMRA_BIT_AUTORUN]) |=> diag_start)
    else $error("Link loss with auto-run did not start diagnostics");

  chk_autorun_off: assert property (@(posedge clk) disable iff (reset)
    !$past(autorun_q[IMRA_BIT_AUTORUN]) |-> !diag_start)
    else $error("Diagnostics started with auto-run clear");

  chk_incrw_adv: assert property (@(posedge clk) disable iff (reset)
    (cmd == IMRA_CMD_INC_RW && dev_vend && win_rd) |=>
      vend_ptr == $past(vend_ptr) + 16'h0001)
    else $error("Pointer did not advance after read with command 10");

  chk_incrw_write: assert property (@(posedge clk) disable iff (reset)
    (cmd == IMRA_CMD_INC_RW && dev_vend && win_wr) |=>
      vend_ptr == $past(vend_ptr) + 16'h0001)
    else $error("Pointer did not advance after write with command 10");

  chk_data_hold: assert property (@(posedge clk) disable iff (reset)
    (cmd == IMRA_CMD_DATA && dev_pma && !$past(reset)) |=> $stable(pma_ptr))
    else $error("Pointer moved under command 01");

  chk_ctrl_write: assert property (@(posedge clk) disable iff (reset)
    (reg_req.wr && reg_req.addr == IMRA_OFF_IND_CTRL) |=>
      (ctrl_q[15:14] == $past(reg_req.wdata[15:14]) && devad == $past(reg_req.wdata[4:0])))
    else $error("Command or device address not taken from control write");

  chk_incwr_read: assert property (@(posedge clk) disable iff (reset)
    (cmd == IMRA_CMD_INC_WR && dev_vend && win_rd && !win_wr) |=> $stable(vend_ptr))
    else $error("Pointer moved on read under command 11");

  chk_incwr_write: assert property (@(posedge clk) disable iff (reset)
    (cmd == IMRA_CMD_INC_WR && dev_pma && win_wr) |=>
      pma_ptr == $past(pma_ptr) + 16'h0001)
    else $error("Pointer did not advance after write under command 11");

  chk_vend_read: assert property (@(posedge clk) disable iff (reset)
    (win_rd && !is_addr && dev_vend) |=> reg_rdata == $past(vend_rdata))
    else $error("Window read did not return vendor space data");

  chk_pma_read: assert property (@(posedge clk) disable iff (reset)
    (win_rd && !is_addr && dev_pma) |=> reg_rdata == $past(pma_rdata))
    else $error("Window read did not return standard space data");

  chk_bad_devad: assert property (@(posedge clk) disable iff (reset)
    !dev_ok |-> (!ext_req.rd && !ext_req.wr) ##1 ($stable(vend_ptr) && $stable(pma_ptr)))
    else $error("Access made with unsupported device address");

  chk_bad_read: assert property (@(posedge clk) disable iff (reset)
    (win_rd && !dev_ok) |=> reg_rdata == 16'h0000)
    else $error("Window read with unsupported device address not zero");

  chk_addr_load: assert property (@(posedge clk) disable iff (reset)
    (win_wr && is_addr && dev_vend) |=> vend_ptr == $past(reg_req.wdata))
    else $error("Address command did not load the pointer");

  chk_pma_load: assert property (@(posedge clk) disable iff (reset)
    (win_wr && is_addr && dev_pma) |=> pma_ptr == $past(reg_req.wdata))
    else $error("Address command did not load the standard space pointer");

  chk_addr_read: assert property (@(posedge clk) disable iff (reset)
    (win_rd && is_addr && dev_ok) |=> reg_rdata == $past(cur_ptr))
    else $error("Window read under command 00 did not return the pointer");

  chk_addr_no_ext: assert property (@(posedge clk) disable iff (reset)
    is_addr |-> (!ext_req.rd && !ext_req.wr))
    else $error("Space accessed under command 00");

  chk_int_polarity: assert property (@(posedge clk) disable iff (reset)
    (!event_irq && !inttest_q[IMRA_BIT_INT_TEST]) ##1 $stable(inttest_q) |->
      int_pin == inttest_q[IMRA_BIT_INT_POL])
    else $error("Idle interrupt pin level does not match polarity");

  chk_event_int: assert property (@(posedge clk) disable iff (reset)
    event_irq |=> int_pin == !$past(inttest_q[IMRA_BIT_INT_POL]))
    else $error("Pending event did not drive the active pin level");

  chk_test_force: assert property (@(posedge clk) disable iff (reset)
    inttest_q[IMRA_BIT_INT_TEST] [*2] |->
      int_pin == !$past(inttest_q[IMRA_BIT_INT_POL]))
    else $error("Test bit did not hold the interrupt active");

  chk_test_clear: assert property (@(posedge clk) disable iff (reset)
    ($fell(inttest_q[IMRA_BIT_INT_TEST]) && !event_irq) |=>
      int_pin == $past(inttest_q[IMRA_BIT_INT_POL]))
    else $error("Forced interrupt did not stop after test bit cleared");

  cov_autorun: cover property (@(posedge clk) disable iff (reset) diag_start);
  cov_vend_data: cover property (@(posedge clk) disable iff (reset)
    ext_req.wr && ext_req.vend);
  cov_pma_read: cover property (@(posedge clk) disable iff (reset)
    ext_req.rd && !ext_req.vend);
  cov_test_int: cover property (@(posedge clk) disable iff (reset)
    inttest_q[IMRA_BIT_INT_TEST] && !inttest_q[IMRA_BIT_INT_POL]);

endmodule

/* File: verif/imra_host.sv */
// Host model: station management side of the register port
`timescale 1ns/10ps
module imra_host (
  // Clock
  input  wire logic          clk,
  // Register port
  output imra_pkg::imra_req_t req,
  input  wire logic [15:0]   rdata
);
  import imra_pkg::*;

  initial req = '0;

  ////////////////////////////////////////////////////////////////
  // Strobe stands over one taken edge, then drops
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
    @(posedge clk);
    req <= '0;
    #1;
  endtask

  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge clk);
    req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 16'h0000};
    @(posedge clk);
    req <= '0;
    #1 d = rdata;
  endtask

  // Pointer first, data command after, same device address
  task automatic win(input logic [4:0] dv, input logic [1:0] cmd, input logic [15:0] off);
    wr(IMRA_OFF_IND_CTRL, {11'h000, dv});
    wr(IMRA_OFF_IND_WINDOW, off);
    wr(IMRA_OFF_IND_CTRL, {cmd, 9'h000, dv});
  endtask
endmodule

/* File: verif/test_indirect_mmd_register_access.sv */
// Testbench: registers, extended window, interrupt pin and auto diagnostics
`timescale 1ns/10ps
module test_indirect_mmd_register_access;
  import imra_pkg::*;
  localparam logic [4:0] WIN = IMRA_OFF_IND_WINDOW;
  localparam logic [4:0] CTL = IMRA_OFF_IND_CTRL;
  logic        clk;
  logic        reset;
  logic        link_up;
  logic        event_irq;
  imra_req_t   reg_req;
  imra_ext_t   ext_req;
  logic [15:0] reg_rdata;
  logic [15:0] vend_rdata;
  logic [15:0] pma_rdata;
  logic        diag_start;
  logic        int_pin;
  logic [15:0] vmem [0:15];
  logic [15:0] pmem [0:15];
  int          num_errors;
  int          compares;
  int          pulses;

  imra_top dut (.clk(clk), .reset(reset), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .ext_req(ext_req), .vend_rdata(vend_rdata), .pma_rdata(pma_rdata), .link_up(link_up),
    .diag_start(diag_start), .event_irq(event_irq), .int_pin(int_pin));
  imra_host host (.clk(clk), .req(reg_req), .rdata(reg_rdata));

  ////////////////////////////////////////////////////////////////
  // Extended spaces: only low offset bits decoded, enough here
  assign vend_rdata = vmem[ext_req.addr[3:0]];
  assign pma_rdata  = pmem[ext_req.addr[3:0]];
  always @(posedge clk) begin
    if (ext_req.wr && ext_req.vend) vmem[ext_req.addr[3:0]] <= ext_req.wdata;
    if (ext_req.wr && !ext_req.vend) pmem[ext_req.addr[3:0]] <= ext_req.wdata;
  end

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [4:0] a, input logic [15:0] exp);
    logic [15:0] d;
    host.rd(a, d);
    chk(d, exp);
  endtask

  task automatic report_and_stop();
    if (num_errors == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Whole run needs well under a thousand cycles
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    report_and_stop();
  end

  initial begin
    reset = 1'b1;
    link_up = 1'b1;
    event_irq = 1'b0;
    num_errors = 0;
    compares = 0;
    for (int i = 0; i < 16; i++) begin
      vmem[i] = 16'ha000 + 16'(i);
      pmem[i] = 16'hb000 + 16'(i);
    end
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk({15'h0000, int_pin}, 16'h0001);
    rchk(IMRA_OFF_DIAG_AUTORUN, 16'h2000);
    rchk(CTL, 16'h0000);
    rchk(IMRA_OFF_INT_TEST, 16'h010b);
    rchk(5'h05, 16'h0000);
    host.wr(CTL, 16'hffff);
    rchk(CTL, 16'hc01f);
    // Advancing on writes, then no advance, then advancing on reads, then pointer readback
    host.win(5'h1f, 2'b10, 16'h04d0);
    host.wr(WIN, 16'h1111);
    host.wr(WIN, 16'h2222);
    host.win(5'h1f, 2'b01, 16'h04d0);
    rchk(WIN, 16'h1111);
    rchk(WIN, 16'h1111);
    host.wr(CTL, 16'h801f);
    rchk(WIN, 16'h1111);
    rchk(WIN, 16'h2222);
    host.wr(CTL, 16'h001f);
    rchk(WIN, 16'h04d2);
    // Advance on writes only
    host.win(5'h1f, 2'b11, 16'h04d0);
    rchk(WIN, 16'h1111);
    rchk(WIN, 16'h1111);
    host.wr(WIN, 16'h3333);
    rchk(WIN, 16'h2222);
    chk(vmem[0], 16'h3333);
    // Second space keeps its own data and pointer
    host.win(5'h01, 2'b01, 16'h0003);
    rchk(WIN, 16'hb003);
    host.wr(WIN, 16'h4444);
    chk(pmem[3], 16'h4444);
    chk(vmem[3], 16'ha003);
    // Unsupported device address touches nothing
    host.win(5'h02, 2'b01, 16'h0000);
    host.wr(WIN, 16'h5555);
    rchk(WIN, 16'h0000);
    chk(pmem[3], 16'h4444);
    chk(vmem[1], 16'h2222);
    host.wr(CTL, 16'h0001);
    rchk(WIN, 16'h0003);
    // Write-only advance in the standard space as well
    host.wr(CTL, 16'hc001);
    host.wr(WIN, 16'h6666);
    rchk(WIN, 16'hb004);
    rchk(WIN, 16'hb004);
    chk(pmem[3], 16'h6666);
    // Every polarity, test and event combination
    for (int k = 0; k < 8; k++) begin
      host.wr(IMRA_OFF_INT_TEST, {12'h010, k[1], k[0], 2'b11});
      @(posedge clk);
      event_irq <= k[2];
      repeat (6) @(posedge clk);
      #1;
      chk({15'h0000, int_pin}, {15'h0000, (k[2] | k[0]) ^ k[1]});
    end
    // Link loss with auto-run off, then on
    for (int e = 0; e < 2; e++) begin
      host.wr(IMRA_OFF_DIAG_AUTORUN, e[0] ? 16'h2100 : 16'h2000);
      pulses = 0;
      @(posedge clk);
      link_up <= 1'b0;
      for (int c = 0; c < 10; c++) begin
        @(posedge clk);
        if (c == 5) link_up <= 1'b1;
        #1 pulses += (diag_start === 1'b1) ? 1 : 0;
      end
      chk(16'(pulses), 16'(e));
    end
    report_and_stop();
  end
endmodule
